// ---- stepper_control.sv ----
// Contract
// - overtemperature: outputs off, indexer to home
// - cooled die resumes on its own
// - any supply low: disable all, home (code leaves clocks_run on in lockout)
// - leave lockout only with both supplies good
// - home reset low: home, bridges off
// - step edges ignored during home reset
// - bridge pin low enables both bridges
// - bridge pin high: bridges off, outputs hi-Z
// - indexer still steps with bridges off
// - low power: bridges, pump, clocks off
// - low power ignores all other inputs but supply low
// - slow, fast or mixed decay selectable
// - drive until trip, then fixed decay
// - after off period, drive again, repeat
// - trip ignored during blanking at drive start
// - full scale sets largest step threshold
// - microstep pins pick steps per full step
// - overcurrent holds bridge off ~800 us (code ends the hold early on a bridge pin toggle)
// - overcurrent returns indexer home
`timescale 1ns/1ps
module stepper_control
  import stepper_pkg::*;
#(
  parameter int OC_CYCLES = OC_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  // controller pins
  input  wire logic       step_pin,
  input  wire logic       direction_pin,
  input  wire logic       home_reset_pin_n,
  input  wire logic       bridge_on_pin_n,
  input  wire logic       low_power_pin_n,
  input  wire logic [1:0] microstep_select_pins,
  // analog flags
  input  wire logic [1:0] chop_trip,
  input  wire logic       overtemp_flag,
  input  wire logic       motor_supply_low,
  input  wire logic       logic_supply_low,
  input  wire logic [1:0] overcurrent_flag,
  // power stage
  output logic [1:0]      bridge_en,
  output logic [1:0]      motor_hiz,
  output logic [1:0]      drive,
  output logic [1:0]      decay_fast,
  output logic [1:0]      decay_slow,
  output logic [1:0]      phase_pos,
  output logic [6:0]      level_a,
  output logic [6:0]      level_b,
  output logic            charge_pump_on,
  output logic            clocks_run
);
  logic [IN_W-1:0] s;
  mode_t      mode;
  mode_t      next_mode;
  logic [4:0] position;
  logic [4:0] next_position;
  logic       prev_step;
  logic       step_edge;
  logic [1:0] oc_hold;
  logic [1:0] oc_event;
  logic [1:0] oc_seen_off;
  logic [15:0] oc_cnt [2];
  logic [1:0] decay_sel;
  logic [7:0] off_cycles;
  logic [7:0] blank_cycles;
  logic       supply_low;
  logic [1:0] next_bridge;

  // cosine of k * 11.25 degrees in percent of full scale
  function automatic logic [6:0] step_level(input logic [3:0] k);
    case (k)
      4'h0:    step_level = 7'h64;
      4'h1:    step_level = 7'h62;
      4'h2:    step_level = 7'h5C;
      4'h3:    step_level = 7'h53;
      4'h4:    step_level = 7'h47;
      4'h5:    step_level = 7'h38;
      4'h6:    step_level = 7'h26;
      4'h7:    step_level = 7'h14;
      default: step_level = 7'h00;
    endcase
  endfunction

  // distance of a position from the nearest cosine peak, 0..8
  function automatic logic [3:0] fold(input logic [4:0] p);
    fold = (p[3:0] <= 4'h8) ? p[3:0] : 4'h0 - p[3:0];
  endfunction

  pin_sync #(.W(IN_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     ({overcurrent_flag, logic_supply_low, motor_supply_low, overtemp_flag,
                chop_trip, microstep_select_pins, low_power_pin_n, bridge_on_pin_n,
                home_reset_pin_n, direction_pin, step_pin}),
    .synced  (s)
  );

  assign supply_low = s[I_MLOW] || s[I_LLOW];
  assign step_edge  = s[I_STEP] && !prev_step;

  always_comb begin
    if (supply_low) begin
      next_mode = M_LOCKOUT;
    end else if (!s[I_SLEEP_N]) begin
      next_mode = M_SLEEP;
    end else if (s[I_HOT]) begin
      next_mode = M_HOT;
    end else begin
      next_mode = M_ACTIVE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= M_LOCKOUT;
    end else begin
      mode <= next_mode;
    end
  end

  // edge tracker runs in sleep too, so waking makes no false step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_step <= 1'b0;
    end else begin
      prev_step <= s[I_STEP];
    end
  end

  always_comb begin
    next_position = position;
    case (mode)
      M_LOCKOUT: next_position = HOME_POS;
      M_HOT:     next_position = HOME_POS;
      M_SLEEP:   next_position = position;
      M_ACTIVE: begin
        if (!s[I_HOME_N] || oc_event != 2'b00) begin
          next_position = HOME_POS;
        end else if (step_edge) begin
          case (s[I_MS_LSB +: 2])
            2'h0:    next_position = s[I_DIR] ? position + 5'h08 : position - 5'h08;
            2'h1:    next_position = s[I_DIR] ? position + 5'h04 : position - 5'h04;
            2'h2:    next_position = s[I_DIR] ? position + 5'h02 : position - 5'h02;
            default: next_position = s[I_DIR] ? position + 5'h01 : position - 5'h01;
          endcase
        end
      end
      default: next_position = HOME_POS;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position <= HOME_POS;
    end else begin
      position <= next_position;
    end
  end

  // winding currents from the step table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_a   <= 7'h00;
      level_b   <= 7'h00;
      phase_pos <= 2'b00;
    end else begin
      level_a   <= step_level(fold(position));
      level_b   <= step_level(4'h8 - fold(position));
      phase_pos <= {position < 5'h10, position < 5'h08 || position >= 5'h18};
    end
  end

  // overcurrent hold per bridge; a new trip is only seen while not held
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_oc
      assign oc_event[i] = mode == M_ACTIVE && bridge_en[i] && s[I_OC_LSB + i]
                           && !oc_hold[i];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          oc_hold[i]     <= 1'b0;
          oc_seen_off[i] <= 1'b0;
          oc_cnt[i]      <= 16'h0000;
        end else if (oc_event[i]) begin
          oc_hold[i]     <= 1'b1;
          oc_seen_off[i] <= 1'b0;
          oc_cnt[i]      <= 16'(OC_CYCLES - 1);
        end else if (oc_hold[i]) begin
          if (oc_cnt[i] == 16'h0000 || (oc_seen_off[i] && !s[I_BRIDGE_N])) begin
            oc_hold[i] <= 1'b0;
          end else begin
            oc_cnt[i] <= oc_cnt[i] - 16'h0001;
          end
          if (s[I_BRIDGE_N]) begin
            oc_seen_off[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      next_bridge[k] = mode == M_ACTIVE && s[I_HOME_N] && !s[I_BRIDGE_N]
                       && !oc_hold[k] && !oc_event[k];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_en      <= 2'b00;
      motor_hiz      <= 2'b11;
      charge_pump_on <= 1'b0;
      clocks_run     <= 1'b0;
    end else begin
      bridge_en      <= next_bridge;
      motor_hiz      <= ~next_bridge;
      charge_pump_on <= next_mode != M_SLEEP && next_mode != M_LOCKOUT;
      clocks_run     <= next_mode != M_SLEEP;
    end
  end

  chop_if cif[2] (.pclk(pclk), .presetn(presetn));
  generate
    for (i = 0; i < 2; i++) begin : g_chop
      assign cif[i].en           = bridge_en[i];
      assign cif[i].trip         = s[I_TRIP_LSB + i];
      assign cif[i].decay_sel    = decay_sel;
      assign cif[i].blank_cycles = blank_cycles;
      assign cif[i].off_cycles   = off_cycles;
      assign drive[i]            = cif[i].drive;
      assign decay_fast[i]       = cif[i].decay_fast;
      assign decay_slow[i]       = cif[i].decay_slow;
      chopper u_chop (.bus(cif[i].chop));
    end
  endgenerate

  // apb: one wait state, write lands at the edge pready is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= paddr != CONTROL_OFS && paddr != STATUS_OFS;
      prdata  <= 32'h0000_0000;
      if (!pwrite && paddr == CONTROL_OFS) begin
        prdata[DECAY_LSB +: 2] <= decay_sel;
        prdata[OFF_LSB +: 8]   <= off_cycles;
        prdata[BLANK_LSB +: 8] <= blank_cycles;
      end else if (!pwrite && paddr == STATUS_OFS) begin
        prdata[ST_MODE_LSB +: 2] <= mode;
        prdata[ST_OC_LSB +: 2]   <= oc_hold;
        prdata[ST_POS_LSB +: 5]  <= position;
        prdata[ST_HIZ_LSB]       <= motor_hiz == 2'b11;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decay_sel    <= DECAY_RESET;
      off_cycles   <= OFF_RESET;
      blank_cycles <= BLANK_RESET;
    end else if (psel && penable && pready && pwrite && paddr == CONTROL_OFS) begin
      decay_sel    <= pwdata[DECAY_LSB +: 2];
      off_cycles   <= pwdata[OFF_LSB +: 8];
      blank_cycles <= pwdata[BLANK_LSB +: 8];
    end
  end

  a_hot_home: assert property (@(posedge pclk) disable iff (!presetn)
    mode == M_HOT |=> position == HOME_POS && bridge_en == 2'b00)
    else $error("overtemperature left outputs on or indexer away from home");

  a_hot_resume: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == M_HOT && !s[I_HOT] && !supply_low && s[I_SLEEP_N]) |=> mode == M_ACTIVE)
    else $error("no automatic resume after cooling");

  a_uv_lock: assert property (@(posedge pclk) disable iff (!presetn)
    supply_low |=> mode == M_LOCKOUT ##1 position == HOME_POS && bridge_en == 2'b00)
    else $error("supply low did not lock out");

  a_uv_exit: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == M_LOCKOUT && supply_low) |=> mode == M_LOCKOUT)
    else $error("lockout left with one supply low");

  a_home_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == M_ACTIVE && !s[I_HOME_N]) |=> position == HOME_POS && bridge_en == 2'b00)
    else $error("home reset not honoured");

  a_bridge_pin: assert property (@(posedge pclk) disable iff (!presetn)
    s[I_BRIDGE_N] |=> bridge_en == 2'b00 && motor_hiz == 2'b11)
    else $error("bridge pin high but outputs driven");

  a_sleep_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == M_SLEEP && next_mode == M_SLEEP) |=> $stable(position) && !clocks_run)
    else $error("activity during low power");

  a_oc_home: assert property (@(posedge pclk) disable iff (!presetn)
    oc_event != 2'b00 |=> position == HOME_POS && (oc_hold & ~bridge_en) == oc_hold)
    else $error("overcurrent did not home and hold");
endmodule

// ---- stepper_pkg.sv ----
package stepper_pkg;

  // register map, byte addresses
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;

  // control register fields
  localparam int DECAY_LSB = 0;
  localparam int OFF_LSB   = 8;
  localparam int BLANK_LSB = 16;

  // status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_OC_LSB   = 2;
  localparam int ST_POS_LSB  = 4;
  localparam int ST_HIZ_LSB  = 9;

  // values after reset
  localparam logic [1:0] DECAY_RESET = 2'h2;
  localparam logic [7:0] OFF_RESET   = 8'hC8;
  localparam logic [7:0] BLANK_RESET = 8'h14;
  localparam logic [4:0] HOME_POS    = 5'h04;

  // decay encodings
  localparam logic [1:0] DECAY_SLOW  = 2'h0;
  localparam logic [1:0] DECAY_FAST  = 2'h1;
  localparam logic [1:0] DECAY_MIXED = 2'h2;

  // positions of the synchronised pin vector
  localparam int IN_W      = 14;
  localparam int I_STEP    = 0;
  localparam int I_DIR     = 1;
  localparam int I_HOME_N  = 2;
  localparam int I_BRIDGE_N = 3;
  localparam int I_SLEEP_N = 4;
  localparam int I_MS_LSB  = 5;
  localparam int I_TRIP_LSB = 7;
  localparam int I_HOT     = 9;
  localparam int I_MLOW    = 10;
  localparam int I_LLOW    = 11;
  localparam int I_OC_LSB  = 12;

  // timing
  localparam int CLK_HZ         = 20_000_000;
  localparam int OC_HOLD_US     = 800;
  localparam int OC_HOLD_CYCLES = OC_HOLD_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {M_LOCKOUT, M_SLEEP, M_HOT, M_ACTIVE} mode_t;

endpackage

// ---- chop_if.sv ----
`timescale 1ns/1ps
interface chop_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic       en;
  logic       trip;
  logic [1:0] decay_sel;
  logic [7:0] blank_cycles;
  logic [7:0] off_cycles;
  logic       drive;
  logic       decay_fast;
  logic       decay_slow;

  modport ctrl (
    output en, trip, decay_sel, blank_cycles, off_cycles,
    input  drive, decay_fast, decay_slow
  );
  modport chop (
    input  pclk, presetn, en, trip, decay_sel, blank_cycles, off_cycles,
    output drive, decay_fast, decay_slow
  );
endinterface

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins in, synchronised out
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] synced
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta   <= '0;
      synced <= '0;
    end else begin
      meta   <= raw;
      synced <= meta;
    end
  end
endmodule

// ---- chopper.sv ----
`timescale 1ns/1ps
module chopper
  import stepper_pkg::*;
(
  chop_if.chop bus
);
  typedef enum logic [1:0] {C_OFF, C_BLANK, C_SENSE, C_DECAY} chop_t;

  chop_t      state;
  logic [7:0] cnt;
  logic [7:0] half_off;

  assign half_off = {1'b0, bus.off_cycles[7:1]};

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      state <= C_OFF;
      cnt   <= 8'h00;
    end else if (!bus.en) begin
      state <= C_OFF;
      cnt   <= 8'h00;
    end else begin
      case (state)
        C_OFF: begin
          state <= C_BLANK;
          cnt   <= bus.blank_cycles;
        end
        C_BLANK: begin
          // trip ignored here; overshoot is accepted
          if (cnt == 8'h00) begin
            state <= C_SENSE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        C_SENSE: begin
          if (bus.trip) begin
            state <= C_DECAY;
            cnt   <= bus.off_cycles;
          end
        end
        C_DECAY: begin
          if (cnt == 8'h00) begin
            state <= C_BLANK;
            cnt   <= bus.blank_cycles;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          state <= C_OFF;
          cnt   <= 8'h00;
        end
      endcase
    end
  end

  // decay flavour of the off period
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      bus.drive      <= 1'b0;
      bus.decay_fast <= 1'b0;
      bus.decay_slow <= 1'b0;
    end else begin
      bus.drive <= bus.en && (state == C_BLANK || state == C_SENSE);
      bus.decay_fast <= bus.en && state == C_DECAY &&
                        (bus.decay_sel == DECAY_FAST ||
                         (bus.decay_sel == DECAY_MIXED && cnt > half_off));
      bus.decay_slow <= bus.en && state == C_DECAY &&
                        (bus.decay_sel == DECAY_SLOW ||
                         (bus.decay_sel == DECAY_MIXED && cnt <= half_off));
    end
  end

  sequence s_trip_seen;
    bus.en && state == C_SENSE && bus.trip;
  endsequence

  sequence s_blank_start;
    bus.en && state == C_BLANK && cnt != 8'h00;
  endsequence

  a_trip_to_decay: assert property (
    @(posedge bus.pclk) disable iff (!bus.presetn)
    s_trip_seen |=> (state == C_DECAY || !bus.en) ##0 (cnt == bus.off_cycles || !bus.en))
    else $error("trip did not start a fixed off period");

  a_blank_holds: assert property (
    @(posedge bus.pclk) disable iff (!bus.presetn)
    s_blank_start |=> state != C_DECAY && state != C_SENSE)
    else $error("blanking window cut short");

  a_decay_ends: assert property (
    @(posedge bus.pclk) disable iff (!bus.presetn)
    (bus.en && state == C_DECAY && cnt == 8'h00) |=> (state == C_BLANK || !bus.en))
    else $error("no new drive phase after off period");
endmodule

// ---- step_source.sv ----
`timescale 1ns/1ps
module step_source (
  // clock
  input  wire logic pclk,
  // pins toward the driver
  output logic      step_pin,
  output logic      direction_pin
);
  initial begin
    step_pin      = 1'b0;
    direction_pin = 1'b1;
  end

  // square wave, 4 cycles per half: above the 1-cycle minimum of the pin sync
  task automatic steps(input int n, input logic dir);
    @(posedge pclk);
    direction_pin <= dir;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      step_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      step_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import stepper_pkg::*;

  logic        pclk                  = 1'b0;
  logic        presetn               = 1'b0;
  logic        psel                  = 1'b0;
  logic        penable               = 1'b0;
  logic        pwrite                = 1'b0;
  logic [7:0]  paddr                 = 8'h00;
  logic [31:0] pwdata                = 32'h0;
  logic        home_reset_pin_n      = 1'b1;
  logic        bridge_on_pin_n       = 1'b0;
  logic        low_power_pin_n       = 1'b1;
  logic [1:0]  microstep_select_pins = 2'h0;
  logic [1:0]  chop_trip             = 2'h0;
  logic        overtemp_flag         = 1'b0;
  logic        motor_supply_low      = 1'b0;
  logic        logic_supply_low      = 1'b0;
  logic [1:0]  overcurrent_flag      = 2'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        step_pin;
  logic        direction_pin;
  logic [1:0]  bridge_en;
  logic [1:0]  motor_hiz;
  logic [1:0]  drive;
  logic [1:0]  decay_fast;
  logic [1:0]  decay_slow;
  logic [1:0]  phase_pos;
  logic [1:0]  exp_dec [4]           = '{2'b01, 2'b10, 2'b10, 2'b00};
  logic [6:0]  level_a;
  logic [6:0]  level_b;
  logic        charge_pump_on;
  logic        clocks_run;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          cmp_count = 0;
  int          n;

  // short overcurrent hold keeps the run brief
  stepper_control #(.OC_CYCLES(20)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_pin(step_pin), .direction_pin(direction_pin),
    .home_reset_pin_n(home_reset_pin_n), .bridge_on_pin_n(bridge_on_pin_n),
    .low_power_pin_n(low_power_pin_n), .microstep_select_pins(microstep_select_pins),
    .chop_trip(chop_trip), .overtemp_flag(overtemp_flag),
    .motor_supply_low(motor_supply_low), .logic_supply_low(logic_supply_low),
    .overcurrent_flag(overcurrent_flag), .bridge_en(bridge_en), .motor_hiz(motor_hiz),
    .drive(drive), .decay_fast(decay_fast), .decay_slow(decay_slow), .phase_pos(phase_pos),
    .level_a(level_a), .level_b(level_b), .charge_pump_on(charge_pump_on),
    .clocks_run(clocks_run)
  );

  step_source ctrl (.pclk(pclk), .step_pin(step_pin), .direction_pin(direction_pin));

  always #25 pclk = ~pclk;

  task automatic end_sim;
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      err_count++;
      end_sim();
    end
  endtask

  function automatic logic [31:0] st(logic [1:0] m, logic [1:0] oc, logic [4:0] p);
    return {23'h0, p, oc, m};
  endfunction

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic wait_drive(input logic v);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (drive[0] !== v && n < 300);
    if (n >= 300) begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic home_pulse;
    @(posedge pclk);
    home_reset_pin_n <= 1'b0;
    cyc(5);
    home_reset_pin_n <= 1'b1;
    cyc(5);
  endtask

  initial begin
    cyc(50000);
    err_count++;
    end_sim();
  end

  initial begin
    cyc(16);
    presetn <= 1'b1;
    cyc(6);
    apb(1'b0, CONTROL_OFS, 32'h0);
    chk(rd, {8'h00, BLANK_RESET, OFF_RESET, 6'h00, DECAY_RESET});
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, st(2'h3, 2'h0, HOME_POS));
    chk({bridge_en, motor_hiz, charge_pump_on, clocks_run}, {2'h3, 2'h0, 2'h3});
    chk({phase_pos, level_a, level_b}, {2'h3, 7'h47, 7'h47});
    // full, half, quarter, eighth
    for (int m = 0; m < 4; m++) begin
      microstep_select_pins <= 2'(m);
      home_pulse();
      ctrl.steps(2, 1'b1);
      cyc(5);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[8:4], 5'(HOME_POS + 2 * (8 >> m)));
      if (m == 0) begin
        chk({phase_pos, level_a, level_b}, {2'h0, 7'h47, 7'h47});
      end
    end
    ctrl.steps(3, 1'b0);
    cyc(5);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd[8:4], 5'h03);
    chk({phase_pos, level_a, level_b}, {2'h3, 7'h53, 7'h38});
    home_reset_pin_n <= 1'b0;
    ctrl.steps(2, 1'b1);
    cyc(5);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({rd[8:4], bridge_en}, {HOME_POS, 2'h0});
    home_reset_pin_n <= 1'b1;
    bridge_on_pin_n  <= 1'b1;
    ctrl.steps(1, 1'b1);
    cyc(5);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({rd[9:4], bridge_en, motor_hiz}, {1'b1, 5'h05, 2'h0, 2'h3});
    bridge_on_pin_n <= 1'b0;
    low_power_pin_n <= 1'b0;
    cyc(6);
    chk({bridge_en, charge_pump_on, clocks_run}, 4'h0);
    ctrl.steps(2, 1'b1);
    low_power_pin_n <= 1'b1;
    cyc(6);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({rd[8:4], bridge_en}, {5'h05, 2'h3});
    overtemp_flag <= 1'b1;
    cyc(6);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, st(2'h2, 2'h0, HOME_POS) | 32'h0000_0200);
    chk(bridge_en, 2'h0);
    overtemp_flag <= 1'b0;
    cyc(6);
    chk(bridge_en, 2'h3);
    ctrl.steps(1, 1'b1);
    motor_supply_low <= 1'b1;
    low_power_pin_n  <= 1'b0;
    cyc(6);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, st(2'h0, 2'h0, HOME_POS) | 32'h0000_0200);
    chk({bridge_en, charge_pump_on}, 3'h0);
    motor_supply_low <= 1'b0;
    logic_supply_low <= 1'b1;
    cyc(6);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd[1:0], 2'h0);
    logic_supply_low <= 1'b0;
    cyc(6);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({rd[1:0], bridge_en}, {2'h1, 2'h0});
    low_power_pin_n <= 1'b1;
    cyc(6);
    chk(bridge_en, 2'h3);
    ctrl.steps(1, 1'b1);
    overcurrent_flag <= 2'h1;
    cyc(2);
    overcurrent_flag <= 2'h0;
    cyc(6);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, st(2'h3, 2'h1, HOME_POS));
    chk(bridge_en, 2'h2);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bridge_en !== 2'h3 && n < 60);
    chk(32'(n > 2 && n < 60), 32'h1);
    // second trip cut short by a bridge pin toggle
    overcurrent_flag <= 2'h2;
    cyc(2);
    overcurrent_flag <= 2'h0;
    cyc(3);
    bridge_on_pin_n <= 1'b1;
    cyc(4);
    bridge_on_pin_n <= 1'b0;
    cyc(6);
    chk(bridge_en, 2'h3);
    // slow, fast, mixed, none
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, CONTROL_OFS, {8'h00, 8'h05, 8'h0A, 6'h0, 2'(d)});
      wait_drive(1'b1);
      chop_trip[0] <= 1'b1;
      wait_drive(1'b0);
      chk({decay_fast[0], decay_slow[0]}, exp_dec[d]);
      chop_trip[0] <= 1'b0;
      wait_drive(1'b1);
      chk(32'(n >= 10 && n <= 12), 32'h1);
      chop_trip[0] <= 1'b1;
      cyc(3);
      chk(drive[0], 1'b1);
      wait_drive(1'b0);
      chop_trip[0] <= 1'b0;
    end
    end_sim();
  end
endmodule
